//--- core/ppe_generator.sv
// top of the parallel port code generator: arbitration, fifo, block sequencing, results
// assumes byte strobes come from transfer logic on the same interface clock

`timescale 1ns/1ps
`default_nettype none

module ppe_generator (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         code_span_select,
  input  wire logic                         code_restart_register,
  input  wire logic                         master_valid,
  input  wire logic [ppe_pkg::DATA_W-1:0]   master_data,
  output var  logic                         master_ready,
  input  wire logic                         slave_valid,
  input  wire logic [ppe_pkg::DATA_W-1:0]   slave_data,
  output var  logic                         slave_ready,
  output var  logic [ppe_pkg::CODE_W-1:0]   first_code_result,
  output var  logic [ppe_pkg::CODE_W-1:0]   second_code_result,
  output var  logic                         first_code_valid,
  output var  logic                         second_code_valid,
  output var  logic                         code_complete,
  output var  logic                         late_traffic,
  output var  logic [ppe_pkg::IDX_W-1:0]    block_byte_count
);
  import ppe_pkg::*;

  localparam logic [LEVEL_W-1:0] SPACE_LVL = LEVEL_W'(FIFO_DEPTH - 1);

  ppe_strm_if fill ();
  ppe_strm_if drain ();

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [LEVEL_W-1:0] level;
  logic               take_master;
  logic               take_slave;
  logic               next_master_ready;
  logic               next_slave_ready;
  logic               space;

  ppe_state_t         state;
  ppe_state_t         next_state;
  logic               span;
  logic               next_span;
  logic [IDX_W-1:0]   idx;
  logic [IDX_W-1:0]   next_idx;
  logic               pending;
  logic               next_pending;
  logic               dest_second;
  logic               next_dest_second;
  logic [CODE_W-1:0]  next_first;
  logic [CODE_W-1:0]  next_second;
  logic               next_first_valid;
  logic               next_second_valid;
  logic               next_complete;
  logic               next_late;

  logic               pop;
  logic               take;
  logic               last;
  logic [CODE_W-1:0]  eng_code;
  logic               eng_done;

  // ----------------------------------------------------------------------
  // last index of the current block
  // ----------------------------------------------------------------------
  function automatic logic is_last(
    input logic [IDX_W-1:0] i,
    input logic             wide
  );
    return wide ? (i == LAST_IDX_LARGE) : (i == LAST_IDX_SMALL);
  endfunction : is_last

  // ----------------------------------------------------------------------
  // source arbitration into the fifo
  // ----------------------------------------------------------------------
  // readies are exclusive, so at most one byte is pushed per cycle; the
  // threshold leaves room for the push that lands while ready lags a cycle
  assign take_master = master_valid & master_ready;
  assign take_slave  = slave_valid & slave_ready;
  assign fill.valid  = take_master | take_slave;
  assign fill.data   = take_master ? master_data : slave_data;
  assign space       = (level < SPACE_LVL) & fill.ready;

  always_comb begin
    next_master_ready = space & ~(slave_valid & ~master_valid);
    next_slave_ready  = space & ~next_master_ready;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_ready <= 1'b0;
      slave_ready  <= 1'b0;
    end else begin
      master_ready <= next_master_ready;
      slave_ready  <= next_slave_ready;
    end
  end

  // ----------------------------------------------------------------------
  // byte buffer; flushed by a restart so stale bytes never count
  // ----------------------------------------------------------------------
  ppe_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (code_restart_register),
    .wr      (fill),
    .rd      (drain),
    .level   (level)
  );

  // drain stalls while a finished code is being stored
  assign drain.ready = ~pending;
  assign pop         = drain.valid & drain.ready & ~code_restart_register;
  assign take        = pop & (state != ST_FROZEN);
  assign last        = is_last(idx, span);

  // ----------------------------------------------------------------------
  // parity engine
  // ----------------------------------------------------------------------
  ppe_code_engine u_engine (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (code_restart_register),
    .take    (take),
    .data    (drain.data),
    .idx     (idx),
    .wide    (span),
    .last    (last),
    .code    (eng_code),
    .done    (eng_done)
  );

  // ----------------------------------------------------------------------
  // block sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_span        = span;
    next_idx         = idx;
    next_pending     = pending;
    next_dest_second = dest_second;
    next_late        = late_traffic;
    if (code_restart_register) begin
      next_state       = ST_BLOCK1;
      next_span        = code_span_select;
      next_idx         = IDX_RESET;
      next_pending     = 1'b0;
      next_dest_second = 1'b0;
      next_late        = 1'b0;
    end else begin
      if (eng_done) begin
        next_pending = 1'b0;
      end
      if (pop && (state == ST_FROZEN)) begin
        next_late = 1'b1;
      end
      case (state)
        ST_BLOCK1: begin
          if (take) begin
            next_idx = last ? IDX_RESET : (idx + 9'h001);
            if (last) begin
              next_pending     = 1'b1;
              next_dest_second = 1'b0;
              next_state       = span ? ST_FROZEN : ST_BLOCK2;
            end
          end
        end
        ST_BLOCK2: begin
          if (take) begin
            next_idx = last ? IDX_RESET : (idx + 9'h001);
            if (last) begin
              next_pending     = 1'b1;
              next_dest_second = 1'b1;
              next_state       = ST_FROZEN;
            end
          end
        end
        ST_FROZEN: begin
          next_idx = idx;
        end
        default: begin
          next_state = ST_BLOCK1;
          next_idx   = IDX_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state        <= ST_BLOCK1;
      span         <= 1'b0;
      idx          <= IDX_RESET;
      pending      <= 1'b0;
      dest_second  <= 1'b0;
      late_traffic <= 1'b0;
    end else begin
      state        <= next_state;
      span         <= next_span;
      idx          <= next_idx;
      pending      <= next_pending;
      dest_second  <= next_dest_second;
      late_traffic <= next_late;
    end
  end

  // ----------------------------------------------------------------------
  // result registers and status
  // ----------------------------------------------------------------------
  always_comb begin
    next_first        = first_code_result;
    next_second       = second_code_result;
    next_first_valid  = first_code_valid;
    next_second_valid = second_code_valid;
    if (code_restart_register) begin
      next_first        = RESULT_RESET;
      next_second       = RESULT_RESET;
      next_first_valid  = 1'b0;
      next_second_valid = 1'b0;
    end else if (eng_done) begin
      if (dest_second) begin
        next_second       = eng_code;
        next_second_valid = 1'b1;
      end else begin
        next_first       = eng_code;
        next_first_valid = 1'b1;
      end
    end
    next_complete = (next_state == ST_FROZEN) & ~next_pending;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      first_code_result  <= RESULT_RESET;
      second_code_result <= RESULT_RESET;
      first_code_valid   <= 1'b0;
      second_code_valid  <= 1'b0;
      code_complete      <= 1'b0;
      block_byte_count   <= IDX_RESET;
    end else begin
      first_code_result  <= next_first;
      second_code_result <= next_second;
      first_code_valid   <= next_first_valid;
      second_code_valid  <= next_second_valid;
      code_complete      <= next_complete;
      block_byte_count   <= next_idx;
    end
  end

endmodule : ppe_generator
`default_nettype wire

//--- core/ppe_pkg.sv
// constants, field layouts and state codes shared by the parallel port code generator
// assumes every file of the block imports it or names it by package scope; no clocking or reset here
package ppe_pkg;

  // ----------------------------------------------------------------------
  // data path widths
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned IDX_W      = 9;
  localparam int unsigned CODE_BYTES = 3;
  localparam int unsigned CODE_W     = 24;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned LEVEL_W    = 4;

  // ----------------------------------------------------------------------
  // block sizes, as last byte index
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] LAST_IDX_SMALL = 9'h0ff;
  localparam logic [IDX_W-1:0] LAST_IDX_LARGE = 9'h1ff;
  localparam logic [IDX_W-1:0] IDX_RESET      = 9'h000;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [CODE_W-1:0] RESULT_RESET = 24'h00_0000;
  localparam logic [DATA_W-1:0] COL_RESET    = 8'h00;
  localparam logic [IDX_W-1:0]  LINE_RESET   = 9'h000;

  // ----------------------------------------------------------------------
  // column parity masks over the xor of all bytes
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] CP0_MASK = 8'h55;
  localparam logic [DATA_W-1:0] CP1_MASK = 8'haa;
  localparam logic [DATA_W-1:0] CP2_MASK = 8'h33;
  localparam logic [DATA_W-1:0] CP3_MASK = 8'hcc;
  localparam logic [DATA_W-1:0] CP4_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] CP5_MASK = 8'hf0;

  // ----------------------------------------------------------------------
  // code layout: byte 2 low pair is padding for small blocks
  // ----------------------------------------------------------------------
  localparam logic [1:0] PAD_BITS = 2'h3;
  localparam int unsigned BYTE2_CP_LSB = 2;

  // ----------------------------------------------------------------------
  // sequencing states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_BLOCK1 = 3'b001,
    ST_BLOCK2 = 3'b010,
    ST_FROZEN = 3'b100
  } ppe_state_t;

endpackage : ppe_pkg

//--- core/ppe_strm_if.sv
// byte stream carrier between the generator top and its fifo
// assumes one clock domain; valid and ready handshake on each edge
`timescale 1ns/1ps
`default_nettype none
interface ppe_strm_if;
  import ppe_pkg::*;
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ppe_strm_if
`default_nettype wire

//--- core/ppe_fifo.sv
// small byte fifo; head word comes out of a register
// assumes push and pop on the same clock; clear empties it, a push in that cycle stays
`timescale 1ns/1ps
`default_nettype none
module ppe_fifo #(
  parameter int unsigned WIDTH = ppe_pkg::DATA_W,
  parameter int unsigned DEPTH = ppe_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     clear,
  ppe_strm_if.snk                       wr,
  ppe_strm_if.src                       rd,
  output var  logic [$clog2(DEPTH):0]   level
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [WIDTH-1:0] head;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [PW:0]      next_level;
  logic [WIDTH-1:0] next_head;
  logic             push;
  logic             pop;
  logic [PW:0]      kept;

  assign wr.ready = (level != FULL_LVL);
  assign rd.valid = (level != '0);
  assign rd.data  = head;
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // ----------------------------------------------------------------------
  // pointers, level and registered head
  // ----------------------------------------------------------------------
  always_comb begin
    kept        = clear ? '0 : (level - (PW+1)'(pop));
    next_rd_ptr = clear ? '0 : (rd_ptr + PW'(pop));
    next_wr_ptr = (clear ? '0 : wr_ptr) + PW'(push);
    next_level  = kept + (PW+1)'(push);
    if ((kept == '0) && push) begin
      next_head = wr.data;
    end else begin
      next_head = mem[next_rd_ptr];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
      head   <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
      head   <= next_head;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[clear ? '0 : wr_ptr] <= wr.data;
    end
  end

endmodule : ppe_fifo
`default_nettype wire

//--- core/ppe_code_engine.sv
// line and column parity accumulator producing one 3-byte code per block
// assumes the caller supplies the byte index and marks the last byte
`timescale 1ns/1ps
`default_nettype none
module ppe_code_engine (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         clear,
  input  wire logic                         take,
  input  wire logic [ppe_pkg::DATA_W-1:0]   data,
  input  wire logic [ppe_pkg::IDX_W-1:0]    idx,
  input  wire logic                         wide,
  input  wire logic                         last,
  output var  logic [ppe_pkg::CODE_W-1:0]   code,
  output var  logic                         done
);
  import ppe_pkg::*;

  logic [DATA_W-1:0] col;
  logic [IDX_W-1:0]  lp_even;
  logic [IDX_W-1:0]  lp_odd;
  logic [DATA_W-1:0] next_col;
  logic [IDX_W-1:0]  next_lp_even;
  logic [IDX_W-1:0]  next_lp_odd;
  logic [CODE_W-1:0] next_code;
  logic              next_done;
  logic              par;

  // ----------------------------------------------------------------------
  // code packing: inverted line parity, column parity, padding
  // ----------------------------------------------------------------------
  function automatic logic [CODE_W-1:0] pack_code(
    input logic [DATA_W-1:0] c,
    input logic [IDX_W-1:0]  le,
    input logic [IDX_W-1:0]  lo,
    input logic              w
  );
    logic [15:0]       lines;
    logic [5:0]        cp;
    logic [DATA_W-1:0] b2;
    lines = '0;
    for (int i = 0; i < 8; i++) begin
      lines[2*i]   = le[i];
      lines[2*i+1] = lo[i];
    end
    cp = {^(c & CP5_MASK), ^(c & CP4_MASK), ^(c & CP3_MASK),
          ^(c & CP2_MASK), ^(c & CP1_MASK), ^(c & CP0_MASK)};
    b2 = {cp, (w ? {lo[8], le[8]} : PAD_BITS)};
    return ~{b2, lines};
  endfunction : pack_code

  // ----------------------------------------------------------------------
  // accumulate one byte per take
  // ----------------------------------------------------------------------
  always_comb begin
    next_col     = col;
    next_lp_even = lp_even;
    next_lp_odd  = lp_odd;
    next_code    = code;
    next_done    = 1'b0;
    par          = ^data;
    if (clear) begin
      next_col     = COL_RESET;
      next_lp_even = LINE_RESET;
      next_lp_odd  = LINE_RESET;
    end else if (take) begin
      next_col = col ^ data;
      for (int i = 0; i < IDX_W; i++) begin
        if (idx[i]) begin
          next_lp_odd[i] = lp_odd[i] ^ par;
        end else begin
          next_lp_even[i] = lp_even[i] ^ par;
        end
      end
      if (last) begin
        next_code    = pack_code(next_col, next_lp_even, next_lp_odd, wide);
        next_done    = 1'b1;
        next_col     = COL_RESET;
        next_lp_even = LINE_RESET;
        next_lp_odd  = LINE_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      col     <= COL_RESET;
      lp_even <= LINE_RESET;
      lp_odd  <= LINE_RESET;
      code    <= RESULT_RESET;
      done    <= 1'b0;
    end else begin
      col     <= next_col;
      lp_even <= next_lp_even;
      lp_odd  <= next_lp_odd;
      code    <= next_code;
      done    <= next_done;
    end
  end

endmodule : ppe_code_engine
`default_nettype wire

//--- tb/ppe_generator_monitor.sv
// checker on the code generator top ports
// assumes bind onto ppe_generator; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module ppe_generator_monitor (
  input wire logic                       clk,
  input wire logic                       reset_n,
  input wire logic                       code_span_select,
  input wire logic                       code_restart_register,
  input wire logic                       master_ready,
  input wire logic                       slave_ready,
  input wire logic [ppe_pkg::CODE_W-1:0] first_code_result,
  input wire logic [ppe_pkg::CODE_W-1:0] second_code_result,
  input wire logic                       first_code_valid,
  input wire logic                       second_code_valid,
  input wire logic                       code_complete,
  input wire logic                       late_traffic,
  input wire logic [ppe_pkg::IDX_W-1:0]  block_byte_count
);
  import ppe_pkg::*;
  logic span;
  logic next_span;
  logic rs;
  assign rs = code_restart_register;
  // mode as latched by the last restart
  always_comb next_span = rs ? code_span_select : span;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      span <= 1'b0;
    else
      span <= next_span;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_one_ready;
    !(master_ready && slave_ready);
  endproperty
  a_one_ready: assert property (p_one_ready) else $error("both readies high");
  property p_clear;
    rs |=> first_code_result == RESULT_RESET && second_code_result == RESULT_RESET
      && !first_code_valid && !code_complete && !late_traffic;
  endproperty
  a_clear: assert property (p_clear) else $error("restart did not clear");
  property p_unused;
    span |-> second_code_result == RESULT_RESET && !second_code_valid;
  endproperty
  a_unused: assert property (p_unused) else $error("second result used");
  property p_done;
    code_complete |-> first_code_valid && (span || second_code_valid);
  endproperty
  a_done: assert property (p_done) else $error("complete without results");
  property p_second_rise;
    $rose(second_code_valid) |-> !span && code_complete;
  endproperty
  a_second_rise: assert property (p_second_rise) else $error("second stored wrongly");
  property p_first_hold;
    first_code_valid && !rs |=> first_code_valid && $stable(first_code_result);
  endproperty
  a_first_hold: assert property (p_first_hold) else $error("first result moved");
  property p_freeze;
    code_complete && !rs |=> code_complete && $stable(second_code_result);
  endproperty
  a_freeze: assert property (p_freeze) else $error("second result moved");
  property p_late;
    late_traffic && !rs |=> late_traffic;
  endproperty
  a_late: assert property (p_late) else $error("late flag dropped");
  property p_count_step;
    $changed(block_byte_count) |-> block_byte_count == IDX_RESET
      || block_byte_count == $past(block_byte_count) + 9'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  property p_bound;
    !span |-> block_byte_count <= LAST_IDX_SMALL;
  endproperty
  a_bound: assert property (p_bound) else $error("small block overran");
  property p_store;
    !rs && !$past(rs) && !first_code_valid && block_byte_count == IDX_RESET
      && $past(block_byte_count) == (span ? LAST_IDX_LARGE : LAST_IDX_SMALL)
      |-> ##[0:4] (first_code_valid || rs);
  endproperty
  a_store: assert property (p_store) else $error("first code not stored");
  c_small: cover property (code_complete && !span);
  c_large: cover property (code_complete && span);
  c_late: cover property ($rose(late_traffic));
endmodule : ppe_generator_monitor
bind ppe_generator ppe_generator_monitor u_ppe_generator_monitor (
  .clk, .reset_n, .code_span_select, .code_restart_register, .master_ready,
  .slave_ready, .first_code_result, .second_code_result, .first_code_valid,
  .second_code_valid, .code_complete, .late_traffic, .block_byte_count
);
`default_nettype wire

//--- tb/ppe_src_model.sv
// byte source standing in for the bus party on one port
// assumes start is a one-cycle pulse; params stay put while busy
`timescale 1ns/1ps
`default_nettype none
module ppe_src_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [9:0] first,
  input  wire logic [9:0] count,
  input  wire logic [1:0] gap,
  input  wire logic [7:0] seed,
  input  wire logic       ready,
  output var  logic       valid,
  output var  logic [7:0] data,
  output var  logic       busy
);
  function automatic logic [7:0] pat(input logic [9:0] i, input logic [7:0] s);
    return (i[7:0] * 8'h3b) ^ {i[9:8], i[7:2]} ^ s;
  endfunction : pat
  initial begin
    valid = 1'b0;
    data = 8'h00;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        for (int i = 0; i < count; i++) begin
          // whole bytes only, never word wide
          valid <= 1'b1;
          data <= pat(first + 10'(i), seed);
          do @(negedge clk); while (!ready);
          @(posedge clk);
          if (gap != 2'h0 || i == count - 1) begin
            valid <= 1'b0;
            data <= ~pat(first + 10'(i), seed);
            repeat (gap) @(posedge clk);
          end
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : ppe_src_model
`default_nettype wire

//--- tb/ppe_generator_tb.sv
// self-checking bench for the parallel port code generator
// assumes one source model per port and the bound checker
`timescale 1ns/1ps
`default_nettype none
module ppe_generator_tb;
  import ppe_pkg::*;
  logic              clk, reset_n, span, rst_pulse, ms, ss;
  logic [9:0]        b_first, b_count;
  logic [1:0]        b_gap;
  logic [7:0]        seed, md, sd;
  logic              mv, sv, mr, sr, mb, sb, v1, v2, done, late;
  logic [CODE_W-1:0] r1, r2;
  logic [IDX_W-1:0]  cnt;
  int                errors, n_tests;
  ppe_generator u_ppe_generator (.clk, .reset_n, .code_span_select(span),
    .code_restart_register(rst_pulse), .master_valid(mv), .master_data(md),
    .master_ready(mr), .slave_valid(sv), .slave_data(sd), .slave_ready(sr),
    .first_code_result(r1), .second_code_result(r2), .first_code_valid(v1),
    .second_code_valid(v2), .code_complete(done), .late_traffic(late),
    .block_byte_count(cnt));
  ppe_src_model u_master_src (.clk, .start(ms), .first(b_first), .count(b_count),
    .gap(b_gap), .seed, .ready(mr), .valid(mv), .data(md), .busy(mb));
  ppe_src_model u_slave_src (.clk, .start(ss), .first(b_first), .count(b_count),
    .gap(b_gap), .seed, .ready(sr), .valid(sv), .data(sd), .busy(sb));
  function automatic logic [7:0] pat(input logic [9:0] i, input logic [7:0] s);
    return (i[7:0] * 8'h3b) ^ {i[9:8], i[7:2]} ^ s;
  endfunction : pat
  // inverted line and column parity, small blocks padded
  function automatic logic [23:0] exp_code(input int f, input int n);
    logic [17:0] lp;
    logic [7:0]  x;
    logic [7:0]  b;
    logic [5:0]  cp;
    lp = '0;
    x = '0;
    for (int i = 0; i < n; i++) begin
      b = pat(10'(f + i), seed);
      x ^= b;
      for (int k = 0; k < 9; k++) lp[2*k + ((i >> k) & 1)] ^= ^b;
    end
    cp = {^(x & 8'hf0), ^(x & 8'h0f), ^(x & 8'hcc), ^(x & 8'h33), ^(x & 8'haa), ^(x & 8'h55)};
    return ~{cp, (n == 512) ? lp[17:16] : 2'h3, lp[15:0]};
  endfunction : exp_code
  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic stall(input string what);
    errors++;
    $display("[ERR] %0t timeout %s", $time, what);
    summarize();
  endtask : stall
  task automatic restart(input logic s);
    @(posedge clk);
    span <= s;
    rst_pulse <= 1'b1;
    @(posedge clk);
    rst_pulse <= 1'b0;
    @(negedge clk);
    check(r1 | r2, RESULT_RESET, "results clear");
    check(24'({v1, v2, done, late, cnt}), 24'h00_0000, "flags clear");
  endtask : restart
  task automatic send(input logic m, input int f, input int n, input logic [1:0] g);
    int k;
    @(posedge clk);
    ms <= m;
    ss <= !m;
    b_first <= 10'(f);
    b_count <= 10'(n);
    b_gap <= g;
    @(posedge clk);
    ms <= 1'b0;
    ss <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while ((mb || sb) && k < 5000);
    if (k >= 5000) stall("source");
    // push, then take and count, then store: three cycles to land
    repeat (3) @(negedge clk);
  endtask : send
  task automatic wait_done;
    int k;
    k = 0;
    while (done !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k >= 50) stall("complete");
  endtask : wait_done
  task automatic t_small;
    restart(1'b0);
    send(1'b1, 0, 256, 2'h0);
    send(1'b0, 256, 256, 2'h1);
    wait_done();
    check(r1, exp_code(0, 256), "first code");
    check(r2, exp_code(256, 256), "second code");
    check(24'({v1, v2, done, cnt}), 24'h00_0e00, "small flags");
    send(1'b1, 512, 20, 2'h0);
    check(r1 ^ exp_code(0, 256), 24'h00_0000, "first frozen");
    check(r2 ^ exp_code(256, 256), 24'h00_0000, "second frozen");
    check(24'(late), 24'h00_0001, "late flag");
    $display("t_small done");
  endtask : t_small
  task automatic t_large;
    restart(1'b1);
    send(1'b0, 0, 300, 2'h0);
    send(1'b1, 300, 212, 2'h2);
    wait_done();
    check(r1, exp_code(0, 512), "large code");
    check(24'({v1, v2, done}), 24'h00_0005, "large flags");
    send(1'b0, 600, 30, 2'h1);
    check(r1 ^ exp_code(0, 512), 24'h00_0000, "large frozen");
    check(r2, RESULT_RESET, "second unused");
    check(24'({late, v2}), 24'h00_0002, "large late");
    $display("t_large done");
  endtask : t_large
  task automatic t_abort;
    restart(1'b0);
    send(1'b1, 0, 100, 2'h1);
    check(24'(cnt), 24'h00_0064, "partial count");
    seed = 8'ha5;
    restart(1'b0);
    send(1'b0, 0, 512, 2'h0);
    wait_done();
    check(r1, exp_code(0, 256), "fresh first");
    check(r2, exp_code(256, 256), "fresh second");
    $display("t_abort done");
  endtask : t_abort
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    span = 1'b0;
    rst_pulse = 1'b0;
    ms = 1'b0;
    ss = 1'b0;
    b_first = 10'h000;
    b_count = 10'h000;
    b_gap = 2'h0;
    seed = 8'h5c;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge clk);
    check(24'({v1, v2, done, late, mr, cnt}), 24'h00_0200, "after reset");
    t_small();
    t_large();
    t_abort();
    summarize();
  end
endmodule : ppe_generator_tb
`default_nettype wire
